// ### hw/rbp_defs.vh
`ifndef RBP_DEFS_VH
`define RBP_DEFS_VH

// Register indexes inside the 1K window; byte address on the bus is four times the index.
`define RBP_IDX_W              10
`define RBP_IDX_PORT_A_DATA    10'h000
`define RBP_IDX_PORT_B_DATA    10'h001
`define RBP_IDX_PORT_A_DIR     10'h002
`define RBP_IDX_PORT_B_DIR     10'h003
`define RBP_IDX_RSVD_LOW_FIRST 10'h004
`define RBP_IDX_RSVD_LOW_LAST  10'h007
`define RBP_IDX_PORT_E_DATA    10'h008
`define RBP_IDX_PORT_E_DIR     10'h009
`define RBP_IDX_PIN_ASSIGN     10'h00a
`define RBP_IDX_MODE_CTRL      10'h00b
`define RBP_IDX_PULLUP_CTRL    10'h00c
`define RBP_IDX_DRIVE_CTRL     10'h00d
`define RBP_IDX_RSVD_E         10'h00e
`define RBP_IDX_RSVD_F         10'h00f
`define RBP_IDX_RAM_POS        10'h010
`define RBP_IDX_BLOCK_POS      10'h011

// Bus address decode: word index = 16-bit CPU address.
`define RBP_ADDR_TOP_MSB       31
`define RBP_ADDR_TOP_LSB       18
`define RBP_ADDR_BASE_MSB      17
`define RBP_ADDR_BASE_LSB      13
`define RBP_ADDR_HALF_BIT      12
`define RBP_ADDR_IDX_MSB       11
`define RBP_ADDR_IDX_LSB       2

// Field positions.
`define RBP_BASE_MSB           7
`define RBP_BASE_LSB           3
`define RBP_MAP_WAIT_BIT       0
`define RBP_PU_A_BIT           0
`define RBP_PU_B_BIT           1
`define RBP_PU_E_BIT           4
`define RBP_PU_H_BIT           5
`define RBP_PU_J_BIT           6
`define RBP_PU_K_BIT           7
`define RBP_PE_PULL_PINS       8'h8f

// Writable bit masks.
`define RBP_PE_DIR_MASK        8'hfc
`define RBP_PAD_CTRL_MASK      8'hf3
`define RBP_RAM_POS_MASK       8'he0
`define RBP_BLOCK_POS_MASK     8'hf9

// Reset values.
`define RBP_DATA_RESET         8'h00
`define RBP_DIR_RESET          8'h00
`define RBP_PIN_ASSIGN_RESET   8'h00
`define RBP_MODE_RESET         8'h00
`define RBP_PULLUP_RESET       8'h10
`define RBP_DRIVE_RESET        8'h00
`define RBP_RAM_POS_RESET      8'h00
`define RBP_BLOCK_POS_RESET    8'h00

`endif

// ### hw/rbp_pad_ctl.v
`timescale 1ns/1ps
`include "rbp_defs.vh"

module rbp_pad_ctl
(
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       ce,
    input  wire [7:0] pullup_ctrl,
    input  wire [7:0] drive_ctrl,
    input  wire [7:0] dir_a,
    input  wire [7:0] dir_b,
    input  wire [7:0] dir_e,
    output reg  [7:0] pullup_pins_a,
    output reg  [7:0] pullup_pins_b,
    output reg  [7:0] pullup_pins_e,
    output reg        pullup_enable_h,
    output reg        pullup_enable_j,
    output reg        pullup_enable_k,
    output reg  [7:0] weak_drive_pins_a,
    output reg  [7:0] weak_drive_pins_b,
    output reg  [7:0] weak_drive_pins_e,
    output reg        weak_drive_h,
    output reg        weak_drive_j,
    output reg        weak_drive_k
);

    // A pull-up only loads a pin that is an input; an output pin drives its own level.
    function [7:0] pull_on_inputs;
        input       en;
        input [7:0] dir;
        begin
            pull_on_inputs = {8{en}} & ~dir;
        end
    endfunction

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // Port E pins 7, 3, 2, 1 and 0 come up pulled, all drives full.
            pullup_pins_a     <= 8'h00;
            pullup_pins_b     <= 8'h00;
            pullup_pins_e     <= `RBP_PE_PULL_PINS;
            pullup_enable_h   <= 1'b0;
            pullup_enable_j   <= 1'b0;
            pullup_enable_k   <= 1'b0;
            weak_drive_pins_a <= 8'h00;
            weak_drive_pins_b <= 8'h00;
            weak_drive_pins_e <= 8'h00;
            weak_drive_h      <= 1'b0;
            weak_drive_j      <= 1'b0;
            weak_drive_k      <= 1'b0;
        end
        else if (ce)
        begin
            pullup_pins_a     <= pull_on_inputs(pullup_ctrl[`RBP_PU_A_BIT], dir_a);
            pullup_pins_b     <= pull_on_inputs(pullup_ctrl[`RBP_PU_B_BIT], dir_b);
            // Pins 6 to 4 of port E have no pull-up device.
            pullup_pins_e     <= pull_on_inputs(pullup_ctrl[`RBP_PU_E_BIT], dir_e)
                                 & `RBP_PE_PULL_PINS;
            pullup_enable_h   <= pullup_ctrl[`RBP_PU_H_BIT];
            pullup_enable_j   <= pullup_ctrl[`RBP_PU_J_BIT];
            pullup_enable_k   <= pullup_ctrl[`RBP_PU_K_BIT];
            weak_drive_pins_a <= {8{drive_ctrl[`RBP_PU_A_BIT]}};
            weak_drive_pins_b <= {8{drive_ctrl[`RBP_PU_B_BIT]}};
            weak_drive_pins_e <= {8{drive_ctrl[`RBP_PU_E_BIT]}};
            weak_drive_h      <= drive_ctrl[`RBP_PU_H_BIT];
            weak_drive_j      <= drive_ctrl[`RBP_PU_J_BIT];
            weak_drive_k      <= drive_ctrl[`RBP_PU_K_BIT];
        end
    end

endmodule

// ### hw/rbp_regblock.v
// Function
// - Register block relocatable on any 2K boundary.
// - Base field supplies top five address bits.
// - Only lower 1K of window decodes.
// - Reset places block at address zero.
// - Pull-up register bits K,J,H,E,B,A; 3:2 zero.
// - Drive register bits K,J,H,E,B,A; 3:2 zero.
// - Port E pull-up enabled out of reset.
// - Other pull-ups off, all drives full.
// - Block position: base 7:3, wait bit 0.
// - RAM position field bits 7:5 only.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "rbp_defs.vh"

module rbp_regblock
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [7:0]  port_a_pin_in,
    output reg  [7:0]  port_a_out,
    output reg  [7:0]  port_a_oe,
    input  wire [7:0]  port_b_pin_in,
    output reg  [7:0]  port_b_out,
    output reg  [7:0]  port_b_oe,
    input  wire [7:0]  port_e_pin_in,
    output reg  [7:0]  port_e_out,
    output reg  [7:0]  port_e_oe,
    output reg  [7:0]  port_e_pin_assignment,
    output reg  [7:0]  operating_mode_control,
    output reg  [7:0]  ram_position,
    output reg  [7:0]  register_block_position,
    output wire [7:0]  pullup_pins_a,
    output wire [7:0]  pullup_pins_b,
    output wire [7:0]  pullup_pins_e,
    output wire        pullup_enable_h,
    output wire        pullup_enable_j,
    output wire        pullup_enable_k,
    output wire [7:0]  weak_drive_pins_a,
    output wire [7:0]  weak_drive_pins_b,
    output wire [7:0]  weak_drive_pins_e,
    output wire        weak_drive_h,
    output wire        weak_drive_j,
    output wire        weak_drive_k
);

    localparam ST_IDLE = 1'b0;
    localparam ST_DATA = 1'b1;

    reg                   state;
    reg                   dp_sel;
    reg                   dp_write;
    reg [`RBP_IDX_W-1:0]  dp_idx;
    reg [7:0]             pullup_enable_control;
    reg [7:0]             reduced_drive_control;
    reg [7:0]             sync1_a;
    reg [7:0]             sync2_a;
    reg [7:0]             sync1_b;
    reg [7:0]             sync2_b;
    reg [7:0]             sync1_e;
    reg [7:0]             sync2_e;

    wire                  accept;
    wire                  ap_sel;
    wire [`RBP_IDX_W-1:0] ap_idx;
    wire [7:0]            wdata;
    reg  [7:0]            read_value;

    // A data register reads the pin on inputs and the latch on outputs.
    function [7:0] pin_view;
        input [7:0] latch;
        input [7:0] dir;
        input [7:0] pin;
        begin
            pin_view = (latch & dir) | (pin & ~dir);
        end
    endfunction

    // Keeps the stored value outside the writable bits and takes the new one inside them.
    function [7:0] masked_write;
        input [7:0] old_value;
        input [7:0] new_value;
        input [7:0] mask;
        begin
            masked_write = (old_value & ~mask) | (new_value & mask);
        end
    endfunction

    assign accept = hsel && htrans[1] && hready && (state == ST_IDLE);
    assign ap_idx = haddr[`RBP_ADDR_IDX_MSB:`RBP_ADDR_IDX_LSB];
    assign wdata  = hwdata[7:0];

    // The window tracks the programmed base, so relocation takes effect on the next transfer.
    assign ap_sel = (haddr[`RBP_ADDR_TOP_MSB:`RBP_ADDR_TOP_LSB] == 14'h0000)
                    && (haddr[`RBP_ADDR_BASE_MSB:`RBP_ADDR_BASE_LSB]
                        == register_block_position[`RBP_BASE_MSB:`RBP_BASE_LSB])
                    && !haddr[`RBP_ADDR_HALF_BIT];

    // Unused or reserved indexes in the 1K window read as zero.
    always @*
    begin
        read_value = 8'h00;
        case (dp_idx)
            `RBP_IDX_PORT_A_DATA: read_value = pin_view(port_a_out, port_a_oe, sync2_a);
            `RBP_IDX_PORT_B_DATA: read_value = pin_view(port_b_out, port_b_oe, sync2_b);
            `RBP_IDX_PORT_A_DIR:  read_value = port_a_oe;
            `RBP_IDX_PORT_B_DIR:  read_value = port_b_oe;
            `RBP_IDX_PORT_E_DATA: read_value = pin_view(port_e_out, port_e_oe, sync2_e);
            `RBP_IDX_PORT_E_DIR:  read_value = port_e_oe;
            `RBP_IDX_PIN_ASSIGN:  read_value = port_e_pin_assignment;
            `RBP_IDX_MODE_CTRL:   read_value = operating_mode_control;
            `RBP_IDX_PULLUP_CTRL: read_value = pullup_enable_control;
            `RBP_IDX_DRIVE_CTRL:  read_value = reduced_drive_control;
            `RBP_IDX_RAM_POS:     read_value = ram_position;
            `RBP_IDX_BLOCK_POS:   read_value = register_block_position;
            default:              read_value = 8'h00;
        endcase
    end

    // Pins are asynchronous to hclk; only the second stage is read.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_a <= 8'h00;
            sync2_a <= 8'h00;
            sync1_b <= 8'h00;
            sync2_b <= 8'h00;
            sync1_e <= 8'h00;
            sync2_e <= 8'h00;
        end
        else if (ce)
        begin
            sync1_a <= port_a_pin_in;
            sync2_a <= sync1_a;
            sync1_b <= port_b_pin_in;
            sync2_b <= sync1_b;
            sync1_e <= port_e_pin_in;
            sync2_e <= sync1_e;
        end
    end

    // Every transfer takes one wait state; the write lands in the first data-phase cycle,
    // so a read right behind a write always sees the new value.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state     <= ST_IDLE;
            dp_sel    <= 1'b0;
            dp_write  <= 1'b0;
            dp_idx    <= {`RBP_IDX_W{1'b0}};
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else if (ce)
        begin
            hresp <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (accept)
                    begin
                        dp_sel    <= ap_sel;
                        dp_write  <= hwrite;
                        dp_idx    <= ap_idx;
                        hreadyout <= 1'b0;
                        state     <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    if (dp_sel && !dp_write)
                    begin
                        hrdata <= {24'h000000, read_value};
                    end
                    else
                    begin
                        hrdata <= 32'h00000000;
                    end
                    hreadyout <= 1'b1;
                    state     <= ST_IDLE;
                end
                default:
                begin
                    hreadyout <= 1'b1;
                    state     <= ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            port_a_out              <= `RBP_DATA_RESET;
            port_b_out              <= `RBP_DATA_RESET;
            port_e_out              <= `RBP_DATA_RESET;
            port_a_oe               <= `RBP_DIR_RESET;
            port_b_oe               <= `RBP_DIR_RESET;
            port_e_oe               <= `RBP_DIR_RESET;
            port_e_pin_assignment   <= `RBP_PIN_ASSIGN_RESET;
            operating_mode_control  <= `RBP_MODE_RESET;
            pullup_enable_control   <= `RBP_PULLUP_RESET;
            reduced_drive_control   <= `RBP_DRIVE_RESET;
            ram_position            <= `RBP_RAM_POS_RESET;
            register_block_position <= `RBP_BLOCK_POS_RESET;
        end
        else if (ce && (state == ST_DATA) && dp_sel && dp_write)
        begin
            case (dp_idx)
                `RBP_IDX_PORT_A_DATA: port_a_out <= wdata;
                `RBP_IDX_PORT_B_DATA: port_b_out <= wdata;
                `RBP_IDX_PORT_A_DIR:  port_a_oe  <= wdata;
                `RBP_IDX_PORT_B_DIR:  port_b_oe  <= wdata;
                `RBP_IDX_PORT_E_DATA: port_e_out <= wdata;
                `RBP_IDX_PORT_E_DIR:
                    port_e_oe <= masked_write(port_e_oe, wdata, `RBP_PE_DIR_MASK);
                `RBP_IDX_PIN_ASSIGN:  port_e_pin_assignment  <= wdata;
                `RBP_IDX_MODE_CTRL:   operating_mode_control <= wdata;
                `RBP_IDX_PULLUP_CTRL:
                    pullup_enable_control <= masked_write(pullup_enable_control, wdata,
                                                          `RBP_PAD_CTRL_MASK);
                `RBP_IDX_DRIVE_CTRL:
                    reduced_drive_control <= masked_write(reduced_drive_control, wdata,
                                                          `RBP_PAD_CTRL_MASK);
                `RBP_IDX_RAM_POS:
                    ram_position <= masked_write(ram_position, wdata,
                                                 `RBP_RAM_POS_MASK);
                `RBP_IDX_BLOCK_POS:
                    register_block_position <= masked_write(register_block_position, wdata,
                                                            `RBP_BLOCK_POS_MASK);
                default:
                begin
                    port_a_out <= port_a_out;
                end
            endcase
        end
    end

    // Pad controls are registered once more so that every pad line comes from a flop.
    rbp_pad_ctl u_pad
    (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .ce                (ce),
        .pullup_ctrl       (pullup_enable_control),
        .drive_ctrl        (reduced_drive_control),
        .dir_a             (port_a_oe),
        .dir_b             (port_b_oe),
        .dir_e             (port_e_oe),
        .pullup_pins_a     (pullup_pins_a),
        .pullup_pins_b     (pullup_pins_b),
        .pullup_pins_e     (pullup_pins_e),
        .pullup_enable_h   (pullup_enable_h),
        .pullup_enable_j   (pullup_enable_j),
        .pullup_enable_k   (pullup_enable_k),
        .weak_drive_pins_a (weak_drive_pins_a),
        .weak_drive_pins_b (weak_drive_pins_b),
        .weak_drive_pins_e (weak_drive_pins_e),
        .weak_drive_h      (weak_drive_h),
        .weak_drive_j      (weak_drive_j),
        .weak_drive_k      (weak_drive_k)
    );

endmodule

// ### verif/rbp_regblock_checker.sv
`timescale 1ns/1ps
module rbp_regblock_checker
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic [7:0]  port_e_oe,
    input wire logic [7:0]  ram_position,
    input wire logic [7:0]  register_block_position,
    input wire logic [7:0]  pullup_pins_e
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire       take = ce && hsel && htrans[1] && hready && hreadyout;
    wire [4:0] base = register_block_position[7:3];
    wire       hit  = haddr[31:18] == 14'h0 && haddr[17:13] == base && !haddr[12];
    sequence s_wait_then_ready;
        !hreadyout ##1 hreadyout;
    endsequence
    a_one_wait_state: assert property (take |=> s_wait_then_ready)
        else $error("transfer did not complete with one wait state");
    a_block_pos_write: assert property (take && hwrite && hit && haddr[11:2] == 10'h011
        |-> ##2 register_block_position == ($past(hwdata[7:0]) & 8'hf9))
        else $error("block position write wrong");
    a_ram_pos_write: assert property (take && hwrite && hit && haddr[11:2] == 10'h010
        |-> ##2 ram_position == ($past(hwdata[7:0]) & 8'he0))
        else $error("ram position write wrong");
    a_far_half_zero: assert property (take && !hwrite && haddr[12] |-> ##2 hrdata == 32'h0)
        else $error("upper half of window answered");
    a_base_miss_kept: assert property (take && hwrite && haddr[17:13] != base
        |-> ##2 register_block_position == $past(register_block_position, 2))
        else $error("write outside window changed block position");
    a_block_pos_gap: assert property (register_block_position[2:1] == 2'b00)
        else $error("block position bits 2:1 not zero");
    a_ram_low_zero: assert property (ram_position[4:0] == 5'h00)
        else $error("ram position low bits not zero");
    a_dir_e_inputs: assert property (port_e_oe[1:0] == 2'b00)
        else $error("port e pins 1:0 driven");
    a_pullup_e_gap: assert property (pullup_pins_e[6:4] == 3'b000)
        else $error("port e pins 6:4 pulled up");
endmodule

bind rbp_regblock rbp_regblock_checker u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .port_e_oe(port_e_oe),
    .ram_position(ram_position), .register_block_position(register_block_position),
    .pullup_pins_e(pullup_pins_e));

// ### verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  pin_a = 8'h00;
    logic [7:0]  pin_b = 8'h00;
    logic [7:0]  pin_e = 8'h00;
    logic [4:0]  base = 5'h00;
    logic [7:0]  mdl [18];
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire  [7:0]  pu_a;
    wire  [7:0]  pu_e;
    wire  [7:0]  wd_e;
    wire         pu_h;
    wire         wd_k;
    wire  [7:0]  pu_b, wd_a, wd_b, out_a, out_b, out_e, oe_a, oe_b, oe_e;
    wire  [7:0]  pin_asg, op_mode, ramp, blkp;
    wire         pu_j, pu_k, wd_h, wd_j, hresp;
    int          num_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    localparam logic [7:0] WM [18] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hff, 8'hfc, 8'hff, 8'hff, 8'hf3, 8'hf3, 8'h00, 8'h00, 8'he0, 8'hf9};

    rbp_regblock DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_a_pin_in(pin_a),
        .port_a_out(out_a), .port_a_oe(oe_a), .port_b_pin_in(pin_b), .port_b_out(out_b),
        .port_b_oe(oe_b), .port_e_pin_in(pin_e), .port_e_out(out_e), .port_e_oe(oe_e),
        .port_e_pin_assignment(pin_asg), .operating_mode_control(op_mode),
        .ram_position(ramp), .register_block_position(blkp), .pullup_pins_a(pu_a),
        .pullup_pins_b(pu_b), .pullup_pins_e(pu_e), .pullup_enable_h(pu_h),
        .pullup_enable_j(pu_j), .pullup_enable_k(pu_k), .weak_drive_pins_a(wd_a),
        .weak_drive_pins_b(wd_b), .weak_drive_pins_e(wd_e), .weak_drive_h(wd_h),
        .weak_drive_j(wd_j), .weak_drive_k(wd_k));

    initial forever #5 hclk = ~hclk;

    task automatic summarize;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // A hung handshake never returns, so the cycle ceiling is the only way out.
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            summarize();
        end
    end

    task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {14'h0, a, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'($urandom()), d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input int i, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, {base, 11'h0} | i, d, r);
        mdl[i] = d & WM[i];
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 8'h00, r);
        `CHK("hrdata", {24'h0, e}, r)
    endtask

    function automatic logic [7:0] ex(int i);
        case (i)
            0: return (mdl[0] & mdl[2]) | (pin_a & ~mdl[2]);
            1: return (mdl[1] & mdl[3]) | (pin_b & ~mdl[3]);
            8: return (mdl[8] & mdl[9]) | (pin_e & ~mdl[9]);
            default: return mdl[i];
        endcase
    endfunction

    task automatic pads;
        repeat (3) @(posedge hclk);
        `CHK("pu_a", {8{mdl[12][0]}} & ~mdl[2], pu_a)
        `CHK("pu_e", {8{mdl[12][4]}} & ~mdl[9] & 8'h8f, pu_e)
        `CHK("pu_h", mdl[12][5], pu_h)
        `CHK("wd_e", {8{mdl[13][4]}}, wd_e)
        `CHK("wd_k", mdl[13][7], wd_k)
        `CHK("pu_b", {8{mdl[12][1]}} & ~mdl[3], pu_b)
        `CHK("pu_jk", mdl[12][7:6], {pu_k, pu_j})
        `CHK("wd_ab", {{8{mdl[13][0]}}, {8{mdl[13][1]}}}, {wd_a, wd_b})
        `CHK("wd_hj", mdl[13][6:5], {wd_j, wd_h})
        `CHK("port_ab", {mdl[0], mdl[1], mdl[2], mdl[3]}, {out_a, out_b, oe_a, oe_b})
        `CHK("port_e", {mdl[8], mdl[9]}, {out_e, oe_e})
        `CHK("pos", {mdl[16], mdl[17]}, {ramp, blkp})
        `CHK("misc", {mdl[10], mdl[11], 1'b0}, {pin_asg, op_mode, hresp})
    endtask

    task automatic model_reset;
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[12] = 8'h10;
        base = 5'h00;
    endtask

    initial
    begin
        logic [4:0] nb;
        logic [31:0] r;
        void'($urandom(10));
        pin_a <= $urandom();
        pin_b <= $urandom();
        pin_e <= $urandom();
        model_reset();
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 18; i++) rd_chk(i, ex(i));
        pads();
        $display("test reset values done");
        repeat (3)
        begin
            pin_a <= $urandom();
            pin_b <= $urandom();
            pin_e <= $urandom();
            for (int i = 0; i < 17; i++) wr(i, $urandom());
            wr(17, {5'h00, 3'($urandom_range(0, 7))});
            for (int i = 0; i < 18; i++) rd_chk(i, ex(i));
            pads();
        end
        $display("test register access done");
        repeat (2)
        begin
            nb = base + $urandom_range(1, 30);
            rd_chk({base, 11'h000}, ex(0));
            wr(17, {nb, 3'($urandom_range(0, 7))});
            base = nb;
            rd_chk({base, 11'h011}, mdl[17]);
            xfer(1'b1, {base ^ 5'h10, 11'h011}, 8'hff, r);
            rd_chk({base, 11'h011}, mdl[17]);
            rd_chk({base ^ 5'h10, 11'h00c}, 8'h00);
            wr(12, $urandom());
            rd_chk({base, 11'h00c}, mdl[12]);
            rd_chk({base, 11'h40c}, 8'h00);
            rd_chk({base, 11'h40c} ^ 16'h0800, 8'h00);
        end
        $display("test relocation done");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        model_reset();
        rd_chk(16'h000c, 8'h10);
        rd_chk(16'h0011, 8'h00);
        pads();
        $display("test second reset done");
        summarize();
    end
endmodule
